// ---- rcd_top.sv ----
/*
  ROM checksum word and self-diagnostic alert registers.
  Assumes a register master with one-cycle strobes, read data next cycle,
  and comparator flags from the analog monitors synchronous to i_clock.
*/
`timescale 1ns/1ps
module rcd_top
  import rcd_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [7:0]                i_addr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [15:0]               o_rdata,
  input  wire logic [ROM_WORDS*16-1:0]   i_rom,
  input  wire logic                      i_zs_active,
  input  wire logic                      i_zs_valid,
  input  wire logic [11:0]               i_zs_result,
  input  wire logic [NUM_CAL*16-1:0]     i_cal_value,
  input  wire logic [2:0]                i_supply_low,
  input  wire logic [2:0]                i_ground_open,
  input  wire logic [NUM_CELLS-1:0]      i_cell_alert,
  output logic      [15:0]               o_diag_select_one,
  output logic      [15:0]               o_diag_select_two,
  output logic      [NUM_CELLS-1:0]      o_cell_alert_masked,
  output logic      [7:0]                o_rom_checksum,
  output logic                           o_crc_done
);
  // ==========================================================
  // submodules
  rcd_cal_if cal ();

  logic [7:0] crc;
  logic       crc_done;

  rcd_crc u_crc (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_rom   (i_rom),
    .o_crc   (crc),
    .o_done  (crc_done)
  );

  rcd_cal_check u_cal (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_cal_value (i_cal_value),
    .cal         (cal)
  );

  // ==========================================================
  // control registers
  logic [15:0] diag_one_q;
  logic [15:0] diag_two_q;
  logic [4:0]  force_q;
  logic [3:0]  top_cell_q;
  logic [11:0] zs_last_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      diag_one_q <= DIAG_SEL_RESET;
      diag_two_q <= DIAG_SEL_RESET;
    end else if (i_wr) begin
      if (hit(i_addr, OFS_DIAG_SELECT_ONE)) diag_one_q <= i_wdata;
      if (hit(i_addr, OFS_DIAG_SELECT_TWO)) diag_two_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      force_q <= 5'h00;
    end else if (i_wr && hit(i_addr, OFS_CAL_FORCE)) begin
      force_q <= i_wdata[4:0];
    end
  end

  // values above the cell count are clamped so no real channel is lost
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      top_cell_q <= TOP_CELL_RESET;
    end else if (i_wr && hit(i_addr, OFS_TOP_CELL_CONFIG)) begin
      top_cell_q <= (i_wdata[3:0] > TOP_CELL_RESET || i_wdata[3:0] == 4'h0)
                    ? TOP_CELL_RESET : i_wdata[3:0];
    end
  end

  assign cal.force_bits = force_q;

  // ==========================================================
  // sticky alerts: set wins over a write-one-to-clear
  logic [6:0]         fa2_q;
  logic [NUM_CAL-1:0] sum_q;
  logic [6:0]         fa2_set;
  logic [NUM_CAL-1:0] sum_set;
  logic [6:0]         fa2_clr;
  logic [NUM_CAL-1:0] sum_clr;

  always_comb begin
    fa2_set = 7'h00;
    fa2_set[FA2_ZERO_SCALE] = i_zs_active && i_zs_valid
                              && (i_zs_result != 12'h000);
    fa2_set[FA2_SUP1 +: 3]  = i_supply_low;
    fa2_set[FA2_GND1 +: 3]  = i_ground_open;
    sum_set = cal.overrange;
    fa2_clr = (i_wr && hit(i_addr, OFS_FAILURE_ALERT_TWO))
              ? i_wdata[6:0] : 7'h00;
    sum_clr = (i_wr && hit(i_addr, OFS_ALERT_SUMMARY))
              ? i_wdata[SUM_CAL0 +: NUM_CAL] : 5'h00;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      fa2_q <= 7'h00;
      sum_q <= 5'h00;
    end else begin
      fa2_q <= (fa2_q & ~fa2_clr) | fa2_set;
      sum_q <= (sum_q & ~sum_clr) | sum_set;
    end
  end

  // last zero-scale conversion kept for readback
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      zs_last_q <= 12'h000;
    end else if (i_zs_active && i_zs_valid) begin
      zs_last_q <= i_zs_result;
    end
  end

  // ==========================================================
  // unused channel masking
  logic [NUM_CELLS-1:0] cell_mask;

  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      cell_mask[c] = (c < int'(top_cell_q));
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cell_alert_masked <= '0;
    end else begin
      o_cell_alert_masked <= i_cell_alert & cell_mask;
    end
  end

  // ==========================================================
  // read port
  logic [15:0] rd_mux;

  always_comb begin
    case (i_addr)
      OFS_CALIB_ROM_CRC_WORD:
        rd_mux = {crc, i_rom[(ROM_WORDS-1)*16 +: 8]};
      OFS_FAILURE_ALERT_TWO: rd_mux = {9'h000, fa2_q};
      OFS_ALERT_SUMMARY:     rd_mux = {11'h000, sum_q};
      OFS_DIAG_SELECT_ONE:   rd_mux = diag_one_q;
      OFS_DIAG_SELECT_TWO:   rd_mux = diag_two_q;
      OFS_CAL_FORCE:         rd_mux = {11'h000, force_q};
      OFS_TOP_CELL_CONFIG:   rd_mux = {12'h000, top_cell_q};
      OFS_ZS_RESULT:         rd_mux = {4'h0, zs_last_q};
      OFS_CELL_ALERT:        rd_mux = {2'h0, o_cell_alert_masked};
      default:               rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  // ==========================================================
  // outputs
  assign o_diag_select_one = diag_one_q;
  assign o_diag_select_two = diag_two_q;
  assign o_rom_checksum    = crc;
  assign o_crc_done        = crc_done;
endmodule

// ---- rcd_pkg.sv ----
/*
  Shared constants for the ROM checksum and diagnostic alert block.
  Assumes a 16-bit register port with a one-cycle read latency.
*/
package rcd_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CALIB_ROM_CRC_WORD = 8'h98;
  localparam logic [7:0] OFS_FAILURE_ALERT_TWO  = 8'hA0;
  localparam logic [7:0] OFS_ALERT_SUMMARY      = 8'hA1;
  localparam logic [7:0] OFS_DIAG_SELECT_ONE    = 8'hA2;
  localparam logic [7:0] OFS_DIAG_SELECT_TWO    = 8'hA3;
  localparam logic [7:0] OFS_CAL_FORCE          = 8'hA4;
  localparam logic [7:0] OFS_TOP_CELL_CONFIG    = 8'hA5;
  localparam logic [7:0] OFS_ZS_RESULT          = 8'hA6;
  localparam logic [7:0] OFS_CELL_ALERT         = 8'hA7;
  // ==========================================================
  // field positions
  localparam int FA2_ZERO_SCALE = 0;
  localparam int FA2_SUP1 = 1;   // three supplies at 1..3
  localparam int FA2_GND1 = 4;   // three grounds at 4..6
  localparam int SUM_CAL0 = 0;   // five cal alerts at 0..4
  // ==========================================================
  // reset values and sizes
  localparam logic [15:0] DIAG_SEL_RESET = 16'h0000;
  localparam logic [3:0]  TOP_CELL_RESET = 4'hE;
  localparam int          NUM_CELLS      = 14;
  localparam int          NUM_CAL        = 5;
  localparam int          ROM_WORDS      = 13;
  localparam logic [7:0]  CRC_POLY       = 8'h4D; // x^8+x^6+x^3+x^2+1
  localparam logic [7:0]  CRC_INIT       = 8'h00;
  // overrange value pushed into the calibration path by a force bit
  localparam logic [15:0] CAL_FORCE_VALUE = 16'hFFFF;
  localparam logic [15:0] CAL_LIMIT       = 16'h7FFF;
endpackage

// ---- rcd_cal_if.sv ----
/*
  Carrier between the top and the calibration checker.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface rcd_cal_if;
  logic [4:0] force_bits;
  logic [4:0] overrange;
  modport top (output force_bits, input overrange);
  modport chk (input force_bits, output overrange);
endinterface

// ---- rcd_crc.sv ----
/*
  Serial CRC-8 over the ROM words, two bytes per word except the checksum byte of the last word.
  Assumes the ROM image is static after reset.
*/
`timescale 1ns/1ps
module rcd_crc
  import rcd_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [ROM_WORDS*16-1:0]   i_rom,
  output logic      [7:0]                o_crc,
  output logic                           o_done
);
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [4:0] idx_q;
  logic [7:0] acc_q;
  logic [7:0] byte_sel;

  // upper byte of each word first; the checksum byte itself is skipped
  always_comb begin
    byte_sel = i_rom[idx_q[4:1]*16 + (idx_q[0] ? 0 : 8) +: 8];
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_q  <= 5'h00;
      acc_q  <= CRC_INIT;
      o_done <= 1'b0;
      o_crc  <= CRC_INIT;
    end else if (!o_done) begin
      if (idx_q == 5'(2*ROM_WORDS - 1)) begin
        o_done <= 1'b1;
        o_crc  <= crc_byte(acc_q, byte_sel);
      end else begin
        // checksum slot stepped over; the count keeps its length
        if (idx_q != 5'(2*ROM_WORDS - 2)) begin
          acc_q <= crc_byte(acc_q, byte_sel);
        end
        idx_q <= idx_q + 5'h01;
      end
    end
  end
endmodule

// ---- rcd_cal_check.sv ----
/*
  Digital calibration range check, one lane per offset or gain path.
  Assumes the analog trims arrive synchronous to the clock.
*/
`timescale 1ns/1ps
module rcd_cal_check
  import rcd_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_rstn,
  input  wire logic [NUM_CAL*16-1:0]   i_cal_value,
  rcd_cal_if.chk                       cal
);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cal.overrange <= 5'h00;
    end else begin
      for (int k = 0; k < NUM_CAL; k++) begin
        // forced value replaces the real trim so the comparator must trip
        cal.overrange[k] <= (cal.force_bits[k] ? CAL_FORCE_VALUE
                             : i_cal_value[k*16 +: 16]) > CAL_LIMIT;
      end
    end
  end
endmodule

// ---- rcd_checker.sv ----
/*
  Checker for rcd_top, bound to its ports.
  Assumes one clock and the one-cycle register port of the design.
*/
`timescale 1ns/1ps
module rcd_checker
  import rcd_pkg::*;
(
  input wire logic                    i_clock,
  input wire logic                    i_rstn,
  input wire logic [7:0]              i_addr,
  input wire logic [15:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [15:0]             o_rdata,
  input wire logic [ROM_WORDS*16-1:0] i_rom,
  input wire logic                    i_zs_active,
  input wire logic                    i_zs_valid,
  input wire logic [11:0]             i_zs_result,
  input wire logic [2:0]              i_supply_low,
  input wire logic [2:0]              i_ground_open,
  input wire logic [NUM_CELLS-1:0]    i_cell_alert,
  input wire logic [15:0]             o_diag_select_one,
  input wire logic [15:0]             o_diag_select_two,
  input wire logic [NUM_CELLS-1:0]    o_cell_alert_masked,
  input wire logic [7:0]              o_rom_checksum,
  input wire logic                    o_crc_done
);
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence rd_fa2;
    i_rd && i_addr == OFS_FAILURE_ALERT_TWO;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_crc_word: assert property ($past(i_rd && o_crc_done) &&
    $past(i_addr) == OFS_CALIB_ROM_CRC_WORD |->
    o_rdata == {o_rom_checksum, i_rom[199:192]})
    else $error("rom word read wrong");
  a_crc_stable: assert property (o_crc_done |=>
    o_crc_done && $stable(o_rom_checksum))
    else $error("checksum moved after done");
  a_diag_one: assert property (i_wr && i_addr == OFS_DIAG_SELECT_ONE
    |=> o_diag_select_one == $past(i_wdata))
    else $error("diag select one not updated");
  a_diag_two: assert property (i_wr && i_addr == OFS_DIAG_SELECT_TWO
    |=> o_diag_select_two == $past(i_wdata))
    else $error("diag select two not updated");
  a_mask_raw: assert property (
    (o_cell_alert_masked & ~$past(i_cell_alert)) == '0)
    else $error("masked alert without raw alert");
  a_zs_alert: assert property (i_zs_active && i_zs_valid &&
    i_zs_result != 12'h000 ##1 rd_fa2 |=> o_rdata[FA2_ZERO_SCALE])
    else $error("zero scale alert missing");
  a_supply_alert: assert property (i_supply_low[0] ##1 rd_fa2
    |=> o_rdata[FA2_SUP1])
    else $error("supply alert missing");
  a_ground_alert: assert property (i_ground_open[2] ##1 rd_fa2
    |=> o_rdata[FA2_GND1+2])
    else $error("ground alert missing");
  a_set_wins: assert property (i_supply_low[0] && i_wr &&
    i_addr == OFS_FAILURE_ALERT_TWO ##[1:2] rd_fa2 |=> o_rdata[FA2_SUP1])
    else $error("clear beat a set");
  c_crc_rd: cover property ($past(i_rd) && o_crc_done);
  c_zs: cover property (i_zs_valid && i_zs_result != 12'h000);
  c_clr: cover property (i_wr && i_addr == OFS_FAILURE_ALERT_TWO);
endmodule
bind rcd_top rcd_checker i_chk (.*);

// ---- tb_top.sv ----
/*
  Self-checking bench for rcd_top over its register port.
  Assumes a static ROM image and comparator flags on i_clock.
*/
`timescale 1ns/1ps
module tb_top;
  import rcd_pkg::*;
  logic                    i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0;
  logic [7:0]              i_addr = 0;
  logic [15:0]             i_wdata = 0, o_rdata, o_ds1, o_ds2;
  logic [ROM_WORDS*16-1:0] i_rom;
  logic                    i_zs_active = 0, i_zs_valid = 0, o_crc_done;
  logic [11:0]             i_zs_result = 0;
  logic [2:0]              i_supply_low = 0, i_ground_open = 0;
  logic [NUM_CELLS-1:0]    i_cell_alert = '1, o_cell;
  logic [7:0]              o_rom_checksum;
  int                      n_mismatch = 0, check_count = 0, cyc = 0;
  logic [15:0]             fa2_exp = 16'h0001;
  rcd_top i_dut (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_rom, .i_zs_active, .i_zs_valid, .i_zs_result,
    .i_cal_value('0), .i_supply_low, .i_ground_open, .i_cell_alert,
    .o_diag_select_one(o_ds1), .o_diag_select_two(o_ds2),
    .o_cell_alert_masked(o_cell), .o_rom_checksum, .o_crc_done);
  initial forever #12.5 i_clock = ~i_clock;
  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the taking edge
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    chk(o_rdata, exp);
  endtask
  function automatic logic [7:0] crc8(input logic [207:0] r);
    logic [7:0] c;
    c = CRC_INIT;
    for (int n = 0; n < 25; n++) begin
      c ^= (n < 24) ? r[16*(n/2)+8*(1-n%2) +: 8] : r[199:192];
      for (int j = 0; j < 8; j++) c = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  // ==========================================================
  // tests
  always @(posedge i_clock) if (++cyc == 5000) begin
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    for (int k = 0; k < ROM_WORDS; k++) i_rom[16*k +: 16] = 16'hA5C3 ^ (k * 16'h1357);
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    chk(o_ds1, 16'h0000);
    chk({2'b00, o_cell}, 16'h0000);
    repeat (2) @(posedge i_clock);
    chk({2'b00, o_cell}, 16'h3FFF);
    for (int i = 0; i < 40 && o_crc_done !== 1'b1; i++) @(posedge i_clock);
    chk({7'h00, o_crc_done, o_rom_checksum},
        {8'h01, crc8(i_rom)});
    rc(OFS_CALIB_ROM_CRC_WORD, {crc8(i_rom), i_rom[199:192]});
    wr(OFS_CALIB_ROM_CRC_WORD, 16'h0000);
    rc(OFS_CALIB_ROM_CRC_WORD, {crc8(i_rom), i_rom[199:192]});
    rc(8'h10, 16'h0000);
    wr(OFS_DIAG_SELECT_ONE, 16'h1234);
    wr(OFS_DIAG_SELECT_TWO, 16'hABCD);
    rc(OFS_DIAG_SELECT_ONE, 16'h1234);
    rc(OFS_DIAG_SELECT_TWO, 16'hABCD);
    chk(o_ds2, 16'hABCD);
    i_zs_active <= 1'b1; i_zs_valid <= 1'b1;
    rc(OFS_FAILURE_ALERT_TWO, 16'h0000);
    i_zs_result <= 12'h001;
    rc(OFS_FAILURE_ALERT_TWO, 16'h0001);
    i_zs_valid <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_supply_low <= 3'b001 << k;
      fa2_exp = fa2_exp | (16'h0002 << k);
      rc(OFS_FAILURE_ALERT_TWO, fa2_exp);
      i_supply_low <= 3'b000;
      i_ground_open <= 3'b001 << k;
      fa2_exp = fa2_exp | (16'h0010 << k);
      rc(OFS_FAILURE_ALERT_TWO, fa2_exp);
      i_ground_open <= 3'b000;
    end
    i_supply_low <= 3'b001;
    wr(OFS_FAILURE_ALERT_TWO, 16'h007F);
    rc(OFS_FAILURE_ALERT_TWO, 16'h0002);
    i_supply_low <= 3'b000;
    wr(OFS_FAILURE_ALERT_TWO, 16'h0002);
    rc(OFS_FAILURE_ALERT_TWO, 16'h0000);
    for (int k = 0; k < NUM_CAL; k++) begin
      wr(OFS_CAL_FORCE, 16'h0001 << k);
      repeat (3) @(posedge i_clock);
      wr(OFS_CAL_FORCE, 16'h0000);
      rc(OFS_ALERT_SUMMARY, (16'h0002 << k) - 16'h0001);
    end
    wr(OFS_ALERT_SUMMARY, 16'h001F);
    rc(OFS_ALERT_SUMMARY, 16'h0000);
    wr(OFS_TOP_CELL_CONFIG, 16'h0005);
    repeat (2) @(posedge i_clock);
    chk({2'b00, o_cell}, 16'h001F);
    wr(OFS_TOP_CELL_CONFIG, 16'h0000);
    repeat (2) @(posedge i_clock);
    chk({2'b00, o_cell}, 16'h3FFF);
    tally_and_finish();
  end
endmodule
